/* inc/relay_spi_pkg.sv */
// Constants for the relay driver serial slave port
package relay_spi_pkg;

	localparam int unsigned FRAME_BITS   = 8;
	localparam int unsigned CNT_W        = 3;
	localparam int unsigned REG_W        = 4;
	localparam int unsigned CTRL_REGS    = 8;
	localparam int unsigned CTRL_PTR_W   = 3;
	localparam int unsigned DIAG_REGS    = 4;
	localparam int unsigned DIAG_PTR_W   = 2;

	// Control bank pointers of the diagnosis current enable registers
	localparam logic [2:0] PTR_DIAG_CURRENT_ENABLE_LOW  = 3'h4;
	localparam logic [2:0] PTR_DIAG_CURRENT_ENABLE_HIGH = 3'h5;

	// Received frame layout
	localparam int unsigned CMD_WRITE_BIT = 7;
	localparam int unsigned CMD_ADDR_MSB  = 6;
	localparam int unsigned CMD_ADDR_LSB  = 4;
	localparam int unsigned CMD_BANK_BIT  = 6;
	localparam int unsigned CMD_DATA_MSB  = 3;
	localparam int unsigned CMD_DATA_LSB  = 0;

	// Returned frame layout
	localparam int unsigned RSP_IND_BIT   = 7;
	localparam int unsigned RSP_BANK_BIT  = 6;

	// Reset values
	localparam logic [3:0] CTRL_REG_RST   = 4'h0;
	localparam logic [7:0] FRAME_RST      = 8'h00;
	localparam logic [2:0] CNT_RST        = 3'h0;

	typedef enum logic [2:0] {
		FS_IDLE   = 3'b001,
		FS_BUSY   = 3'b010,
		FS_DECODE = 3'b100
	} frame_state_t;

endpackage

/* design/relay_driver_spi_slave.sv */
// Serial slave port with control and diagnosis register banks
//
// What this block does
// RULE1 - Each diagnosis current enable bit switches one channel's diagnosis current on or off.
// RULE2 - Low enable register sits at control pointer 100, high one at 101.
// RULE3 - Full duplex serial slave on select, clock, input and output lines.
// RULE4 - Select falling starts an access; master ends each with select rising.
// RULE5 - Input sampled on falling clock edge; output changes on rising edge.
// RULE6 - Data accepted only after a nonzero multiple of eight clock pulses; after reset or a good frame, every second clockless frame is accepted.
// RULE7 - Wrong pulse count sets the transmission error flag and drops the command; after reset or a good frame, every second clockless frame counts as good.
// RULE8 - Select high: clock and input ignored, output released to high impedance.
// RULE9 - Select falling loads current diagnosis information into the shift register.
// RULE10 - Select falling drives output with error flag OR input until first rising clock.
// RULE11 - Select rising copies the shift register into the input matrix register.
// RULE12 - Master keeps serial clock low while select changes.
// RULE13 - Both directions move the most significant bit first.
// RULE14 - Input frames are eight bits: control part then data part.
// RULE15 - One shift register passes frames to a chained neighbour after eight clocks.
// RULE16 - Chained devices need eight clocks each before select rises.
// RULE17 - Control bank of eight four-bit registers chosen by a three-bit pointer.
// RULE18 - Diagnosis bank of four four-bit registers chosen by a two-bit pointer.
// RULE19 - Returned frames carry a bit telling standard diagnosis from register read-back.
// RULE20 - Reset returns protocol state and registers to defaults.
// RULE21 - Select and input are synchronised in the system clock; only select is edge detected.
`timescale 1ns/10ps
module relay_driver_spi_slave
	import relay_spi_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        si_i,
	output logic             so_o,
	output logic             so_oe_o,
	input  wire logic [6:0]  diag_std_i,
	input  wire logic [15:0] diag_bank_i,
	output logic [7:0]       channel_diag_current_on_o,
	output logic [31:0]      ctrl_regs_o,
	output logic [7:0]       imr_o,
	output logic             imr_valid_o,
	output logic             transmission_error_flag_o
);

	logic               cs_s1_r;
	logic               cs_s2_r;
	logic               cs_s3_r;
	logic               si_s1_r;
	logic               si_s2_r;
	logic               cs_fall;
	logic               cs_rise;
	frame_state_t       state_r;
	logic               frame_id_r;
	logic [7:0]         tx_word_r;
	logic [7:0]         tx_nxt;
	logic [3:0]         read_data;
	logic               read_pend_r;
	logic               read_bank_r;
	logic [2:0]         read_ptr_r;
	logic [7:0]         imr_r;
	logic               imr_valid_r;
	logic               frame_ok;
	logic               frame_ok_r;
	logic               ter_r;
	logic               so_oe_r;
	logic               lead_so_r;
	logic [REG_W-1:0]   ctrl_bank_r [CTRL_REGS];
	logic [7:0]         sr_r;
	logic [CNT_W-1:0]   bit_cnt_r;
	logic               seen_id_r;
	logic               started_r;
	logic               so_started_r;
	logic               so_bit_r;

	// Pin synchronisers
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_s3_r <= 1'b1;
			si_s1_r <= 1'b0;
			si_s2_r <= 1'b0;
		end
		else
		begin
			cs_s1_r <= cs_n_i; // RULE21
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
			si_s1_r <= si_i;
			si_s2_r <= si_s1_r;
		end
	end

	assign cs_fall = cs_s3_r & ~cs_s2_r; // RULE4
	assign cs_rise = ~cs_s3_r & cs_s2_r; // RULE4

	// Link side: shift on falling clock, held while select is high
	always_ff @(posedge cs_n_i or posedge rst_i or negedge sclk_i)
	begin
		if (cs_n_i || rst_i)
			started_r <= 1'b0;
		else
			started_r <= 1'b1;
	end

	always_ff @(negedge sclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sr_r      <= FRAME_RST;
			bit_cnt_r <= CNT_RST;
			seen_id_r <= 1'b0;
		end
		else if (!cs_n_i) // RULE8
		begin
			if (!started_r)
			begin
				sr_r      <= {tx_word_r[6:0], si_i}; // RULE5 RULE9
				bit_cnt_r <= CNT_W'(1); // RULE6
				seen_id_r <= frame_id_r;
			end
			else
			begin
				sr_r      <= {sr_r[6:0], si_i}; // RULE13 RULE15
				bit_cnt_r <= bit_cnt_r + CNT_W'(1); // RULE6
			end
		end
	end

	// Link side: output bit changes on rising clock
	always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i)
	begin
		if (cs_n_i || rst_i)
		begin
			so_started_r <= 1'b0;
			so_bit_r     <= 1'b0;
		end
		else
		begin
			so_started_r <= 1'b1;
			so_bit_r     <= started_r ? sr_r[7] : tx_word_r[7]; // RULE5 RULE13 RULE15
		end
	end

	// Output driver: lead value before the first rising clock, then shifted data
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			so_oe_r   <= 1'b0;
			lead_so_r <= 1'b0;
		end
		else
		begin
			so_oe_r   <= ~cs_s2_r; // RULE8 RULE3
			lead_so_r <= ter_r | si_s2_r; // RULE10
		end
	end

	assign so_o    = so_started_r ? so_bit_r : lead_so_r; // RULE10
	assign so_oe_o = so_oe_r;

	// Response word for the next frame
	always_comb
	begin
		if (read_bank_r)
			read_data = diag_bank_i[{read_ptr_r[DIAG_PTR_W-1:0], 2'b00} +: REG_W]; // RULE18
		else
			read_data = ctrl_bank_r[read_ptr_r]; // RULE17
		if (read_pend_r)
			tx_nxt = {1'b1, read_bank_r, 2'b00, read_data}; // RULE19
		else
			tx_nxt = {1'b0, diag_std_i}; // RULE19
	end

	// Frame sequencing
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			state_r <= FS_IDLE;
		else
		begin
			case (state_r)
				FS_IDLE:   state_r <= cs_fall ? FS_BUSY : FS_IDLE;
				FS_BUSY:   state_r <= cs_rise ? FS_DECODE : FS_BUSY;
				FS_DECODE: state_r <= FS_IDLE;
				default:   state_r <= FS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			frame_id_r <= 1'b0;
			tx_word_r  <= FRAME_RST;
		end
		else if (cs_fall)
		begin
			frame_id_r <= ~frame_id_r;
			tx_word_r  <= tx_nxt; // RULE9
		end
	end

	assign frame_ok = (seen_id_r == frame_id_r) && (bit_cnt_r == CNT_RST); // RULE6

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			imr_r       <= FRAME_RST;
			imr_valid_r <= 1'b0;
			frame_ok_r  <= 1'b0;
		end
		else
		begin
			imr_valid_r <= cs_rise && frame_ok; // RULE6
			if (cs_rise)
			begin
				imr_r      <= sr_r; // RULE11
				frame_ok_r <= frame_ok;
			end
		end
	end

	// Transmission error flag: set by a bad frame, cleared by a good one
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			ter_r <= 1'b0;
		else if (cs_rise)
			ter_r <= ~frame_ok; // RULE7
	end

	// Command decode into the register banks
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < CTRL_REGS; i++)
				ctrl_bank_r[i] <= CTRL_REG_RST; // RULE20
		end
		else if (state_r == FS_DECODE && frame_ok_r && imr_r[CMD_WRITE_BIT]) // RULE7 RULE14
			ctrl_bank_r[imr_r[CMD_ADDR_MSB:CMD_ADDR_LSB]] <=
				imr_r[CMD_DATA_MSB:CMD_DATA_LSB]; // RULE1 RULE17
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			read_pend_r <= 1'b0;
			read_bank_r <= 1'b0;
			read_ptr_r  <= 3'h0;
		end
		else if (state_r == FS_DECODE && frame_ok_r)
		begin
			read_pend_r <= ~imr_r[CMD_WRITE_BIT];
			read_bank_r <= imr_r[CMD_BANK_BIT];
			read_ptr_r  <= imr_r[2:0];
		end
		else if (cs_fall)
			read_pend_r <= 1'b0;
	end

	assign channel_diag_current_on_o = {ctrl_bank_r[PTR_DIAG_CURRENT_ENABLE_HIGH],
		ctrl_bank_r[PTR_DIAG_CURRENT_ENABLE_LOW]}; // RULE1 RULE2
	assign ctrl_regs_o = {ctrl_bank_r[7], ctrl_bank_r[6], ctrl_bank_r[5], ctrl_bank_r[4],
		ctrl_bank_r[3], ctrl_bank_r[2], ctrl_bank_r[1], ctrl_bank_r[0]};
	assign imr_o                     = imr_r;
	assign imr_valid_o               = imr_valid_r;
	assign transmission_error_flag_o = ter_r;

	// Checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	a_oe_release: assert property ($rose(cs_s2_r) |=> !so_oe_o) // RULE8
		else $error("Output still enabled after select rose");
	a_oe_drive: assert property ($fell(cs_s2_r) |=> so_oe_o ##0 !so_started_r) // RULE10
		else $error("Output not driven with lead value after select fell");
	a_ter_on_bad: assert property (cs_rise && !frame_ok |=> ter_r) // RULE7
		else $error("Error flag not set after bad frame");
	a_no_decode_bad: assert property (state_r == FS_DECODE && !frame_ok_r // RULE7
		|=> $stable(ctrl_regs_o))
		else $error("Registers changed after bad frame");
	a_imr_copy: assert property (cs_rise |=> imr_r == $past(sr_r)) // RULE11
		else $error("Input matrix register not loaded at select rise");
	a_valid_pulse: assert property (imr_valid_o |=> !imr_valid_o ##1 state_r == FS_IDLE) // RULE6
		else $error("Accept pulse longer than one cycle");
	a_write_low: assert property (state_r == FS_DECODE && frame_ok_r && imr_r[7] // RULE1 RULE2
		&& imr_r[6:4] == PTR_DIAG_CURRENT_ENABLE_LOW
		|=> channel_diag_current_on_o[3:0] == $past(imr_r[3:0]))
		else $error("Low enable register not written");
	a_tx_load: assert property (cs_fall |=> tx_word_r == $past(tx_nxt)) // RULE9
		else $error("Diagnosis word not loaded at select fall");
	a_lead_value: assert property (cs_fall |=> lead_so_r == ($past(ter_r) | $past(si_s2_r))) // RULE10
		else $error("Lead output value wrong");
	a_readback_ind: assert property (cs_fall && read_pend_r |=> tx_word_r[7] ##1 !read_pend_r) // RULE19
		else $error("Read-back indication missing");
	a_reset_state: assert property (@(posedge clk_sys_i) disable iff (1'b0) rst_i // RULE20
		|=> ctrl_regs_o == 32'h0 && !transmission_error_flag_o && !so_oe_o && imr_o == 8'h00)
		else $error("Defaults not restored by reset");

	// Accept, decode and response checks
	a_valid_good: assert property (cs_rise && frame_ok |=> imr_valid_o) // RULE6
		else $error("Good frame not accepted");
	a_count_reject: assert property (cs_rise && !frame_ok |=> !imr_valid_o) // RULE6
		else $error("Bad frame accepted");
	a_ter_clear: assert property (cs_rise && frame_ok |=> !ter_r) // RULE7
		else $error("Error flag not cleared by good frame");
	a_decode_after_rise: assert property (cs_rise |=> state_r == FS_DECODE) // RULE11
		else $error("Frame end not followed by decode");
	a_oe_idle: assert property (cs_s2_r |=> !so_oe_o) // RULE8
		else $error("Output enabled while deselected");
	a_std_response: assert property (cs_fall && !read_pend_r // RULE9 RULE19
		|=> tx_word_r == {1'b0, $past(diag_std_i)})
		else $error("Standard diagnosis word not loaded");
	a_diag_select: assert property (cs_fall && read_pend_r && read_bank_r // RULE18 RULE19
		|=> tx_word_r[RSP_BANK_BIT])
		else $error("Diagnosis bank indication missing");
	a_write_high: assert property (state_r == FS_DECODE && frame_ok_r && imr_r[7] // RULE1 RULE2
		&& imr_r[6:4] == PTR_DIAG_CURRENT_ENABLE_HIGH
		|=> channel_diag_current_on_o[7:4] == $past(imr_r[3:0]))
		else $error("High enable register not written");
	a_bank_quiet: assert property (state_r != FS_DECODE |=> $stable(ctrl_regs_o)) // RULE17
		else $error("Registers changed without a decode");
	a_read_no_write: assert property (state_r == FS_DECODE && frame_ok_r // RULE14
		&& !imr_r[CMD_WRITE_BIT] |=> $stable(ctrl_regs_o))
		else $error("Read command changed a register");
	a_read_pending: assert property (state_r == FS_DECODE && frame_ok_r // RULE19
		&& !imr_r[CMD_WRITE_BIT] |=> read_pend_r)
		else $error("Read command did not queue a response");

	c_good_write: cover property (state_r == FS_DECODE && frame_ok_r && imr_r[7]);
	c_bad_frame: cover property (cs_rise && !frame_ok);
	c_read_back: cover property (cs_fall && read_pend_r);
	c_ter_cleared: cover property ($fell(ter_r));
	c_diag_read: cover property (cs_fall && read_pend_r && read_bank_r);

endmodule // relay_driver_spi_slave

/* verif/spi_master_model.sv */
// Serial bus master model driving the slave port
`timescale 1ns/10ps
module spi_master_model
(
	output logic     cs_n_o,
	output logic     sclk_o,
	output logic     si_o,
	input  wire logic so_i,
	input  wire logic so_oe_i
);
	logic so_last = 1'b0;
	wire  so_line;

	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o = 1'b0;
	end

	always @(so_i or so_oe_i)
		if (so_oe_i)
			so_last = so_i;
	// Released line shows the inverse of its last level
	assign so_line = so_oe_i ? so_i : ~so_last;

	// Sends n bits of tx, returns the bits seen on the output
	task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx,
		output logic lead, output logic oe);
		rx = '0;
		sclk_o = 1'b0;
		cs_n_o = 1'b0;
		si_o = tx[n-1];
		#200;
		lead = so_line;
		oe = so_oe_i;
		for (int i = n - 1; i >= 0; i--)
		begin
			si_o = tx[i];
			#12 sclk_o = 1'b1;
			#16 sclk_o = 1'b0;
			rx = {rx[22:0], so_line};
			#4;
		end
		#40 cs_n_o = 1'b1;
		si_o = ~si_o;
		#200;
	endtask

	// Clock and input activity while deselected
	task automatic idle_noise();
		repeat (4)
		begin
			si_o = ~si_o;
			#16 sclk_o = 1'b1;
			#16 sclk_o = 1'b0;
		end
	endtask
endmodule // spi_master_model

/* verif/tb.sv */
// Testbench for the relay driver serial slave port
`timescale 1ns/10ps
module tb;
	import relay_spi_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_i;
	wire         sclk_i;
	wire         cs_n_i;
	wire         si_i;
	logic        so_o;
	logic        so_oe_o;
	logic [6:0]  diag_std_i = 7'h2b;
	logic [15:0] diag_bank_i = 16'h9c3e;
	logic [7:0]  chan_on;
	logic [31:0] regs;
	logic [7:0]  imr;
	logic        imr_valid;
	logic        transmission_error_flag;
	int          err_total = 0;
	int          samples_checked = 0;
	int          valid_cnt = 0;
	int          cyc = 0;
	int          v;
	logic [23:0] rx;
	logic        lead;
	logic        oe;

	relay_driver_spi_slave uut (
		.clk_sys_i                 (clk_sys_i),
		.rst_i                     (rst_i),
		.sclk_i                    (sclk_i),
		.cs_n_i                    (cs_n_i),
		.si_i                      (si_i),
		.so_o                      (so_o),
		.so_oe_o                   (so_oe_o),
		.diag_std_i                (diag_std_i),
		.diag_bank_i               (diag_bank_i),
		.channel_diag_current_on_o (chan_on),
		.ctrl_regs_o               (regs),
		.imr_o                     (imr),
		.imr_valid_o               (imr_valid),
		.transmission_error_flag_o (transmission_error_flag)
	);

	spi_master_model mst (
		.cs_n_o  (cs_n_i),
		.sclk_o  (sclk_i),
		.si_o    (si_i),
		.so_i    (so_o),
		.so_oe_i (so_oe_o)
	);

	always #10 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (imr_valid === 1'b1)
			valid_cnt <= valid_cnt + 1;
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic t_write_all();
		for (int p = 0; p < 8; p++)
		begin
			mst.xfer({16'h0, 1'b1, p[2:0], ~p[3:0]}, 8, rx, lead, oe);
			chk(imr, {1'b1, p[2:0], ~p[3:0]});
			chk(regs[4*p +: 4], {28'h0, ~p[3:0]});
			chk(oe, 1'b1);
		end
		chk(chan_on, 8'hab);
		chk(valid_cnt, 8);
	endtask

	task automatic t_readback();
		mst.xfer(24'h04, 8, rx, lead, oe);
		chk(rx[7:0], {1'b0, diag_std_i});
		chk(lead, 1'b0);
		mst.xfer(24'h42, 8, rx, lead, oe);
		chk(rx[7:0], 8'h8b);
		mst.xfer(24'h00, 8, rx, lead, oe);
		chk(rx[7:0], {4'hc, diag_bank_i[11:8]});
	endtask

	task automatic t_bad_count();
		v = valid_cnt;
		mst.xfer(24'h1f, 5, rx, lead, oe);
		chk(transmission_error_flag, 1'b1);
		chk(valid_cnt, v);
		chk(regs, 32'h89abcdef);
		mst.xfer(24'h10, 8, rx, lead, oe);
		chk(lead, 1'b1);
		chk(transmission_error_flag, 1'b0);
	endtask

	task automatic t_chain();
		mst.xfer(24'hd307, 16, rx, lead, oe);
		chk(rx[15:0], 16'h8fd3);
		chk(imr, 8'h07);
		chk(regs, 32'h89abcdef);
	endtask

	task automatic t_idle();
		v = valid_cnt;
		mst.idle_noise();
		chk(so_oe_o, 1'b0);
		chk(valid_cnt, v);
		chk(imr, 8'h07);
	endtask

	task automatic t_reset();
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk(regs, 32'h0);
		chk(imr, 8'h00);
		chk(so_oe_o, 1'b0);
		mst.xfer(24'ha5, 8, rx, lead, oe);
		chk(rx[7:0], {1'b0, diag_std_i});
		chk(regs, 32'h00000500);
	endtask

	initial
	begin
		rst_i <= 1'b1;
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk(so_oe_o, 1'b0);
		chk(regs, 32'h0);
		chk(transmission_error_flag, 1'b0);
		t_write_all();
		t_readback();
		t_bad_count();
		t_chain();
		t_idle();
		t_reset();
		conclude();
	end
endmodule // tb
